// *** amp_regmap.sv ***
`timescale 1ns/1ps

module amp_regmap
    import amp_regmap_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // Register port from the control bus
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_rvalid_o,
    // Status inputs from the analog and protection blocks
    input  wire logic        power_stage_undervolt_i,
    input  wire logic        regulator_undervolt_i,
    input  wire logic        overtemp_fault_flag_i,
    input  wire logic        overtemp_warning_flag_i,
    input  wire logic [3:0]  right_events_i,
    input  wire logic [3:0]  left_events_i,
    input  wire logic [7:0]  supply_code_i,
    input  wire logic [7:0]  temperature_code_i,
    // Control outputs to the datapath
    output logic      [7:0]  power_control_o,
    output logic      [7:0]  amp_dac_setup_o,
    output logic      [7:0]  dac_setup_o,
    output logic      [7:0]  left_volume_level_o,
    output logic      [7:0]  right_volume_level_o,
    output logic      [7:0]  serial_port_setup_a_o,
    output logic      [7:0]  serial_port_setup_b_o,
    output logic      [4:0]  left_slot_o,
    output logic      [4:0]  right_slot_o,
    output logic      [7:0]  left_limiter_rates_o,
    output logic      [7:0]  left_limiter_threshold_o,
    output logic      [7:0]  left_supply_knee_o,
    output logic      [7:0]  right_limiter_rates_o,
    output logic      [7:0]  right_limiter_threshold_o,
    output logic      [7:0]  right_supply_knee_o,
    output logic      [7:0]  left_clipper_level_o,
    output logic      [7:0]  right_clipper_level_o,
    output logic      [7:0]  thermal_gain_reduction_o,
    output logic      [7:0]  fault_recovery_setup_o,
    output logic             manual_recover_pulse_o
);

    // ------------------------------------------------------------
    // Register table
    // ------------------------------------------------------------
    // Address, reset value and writable mask of each writable register
    localparam logic [7:0] RW_ADDR  [NUM_RW] = '{
        ADDR_POWER_CONTROL, ADDR_AMP_DAC_SETUP, ADDR_DAC_SETUP,
        ADDR_LEFT_VOLUME, ADDR_RIGHT_VOLUME, ADDR_SERIAL_PORT_A,
        ADDR_SERIAL_PORT_B, ADDR_LEFT_SLOT, ADDR_RIGHT_SLOT,
        ADDR_LEFT_LIM_RATES, ADDR_LEFT_LIM_THRESH, ADDR_LEFT_LIM_INFL,
        ADDR_RIGHT_LIM_RATES, ADDR_RIGHT_LIM_THRESH, ADDR_RIGHT_LIM_INFL,
        ADDR_LEFT_CLIPPER, ADDR_RIGHT_CLIPPER, ADDR_THERMAL_GAIN,
        ADDR_FAULT_RECOVERY, ADDR_SOFT_RESET, ADDR_SUPPLY_FLAGS,
        ADDR_CHANNEL_FLAGS, ADDR_SUPPLY_READING};
    localparam logic [7:0] RW_RESET [NUM_RW] = '{
        RST_POWER_CONTROL, RST_AMP_DAC_SETUP, RST_DAC_SETUP,
        RST_LEFT_VOLUME, RST_RIGHT_VOLUME, RST_SERIAL_PORT_A,
        RST_SERIAL_PORT_B, RST_LEFT_SLOT, RST_RIGHT_SLOT,
        RST_LEFT_LIM_RATES, RST_LIM_THRESH, RST_LIM_INFL,
        RST_RIGHT_LIM_RATES, RST_LIM_THRESH, RST_LIM_INFL,
        RST_CLIPPER, RST_CLIPPER, RST_THERMAL_GAIN,
        RST_FAULT_RECOVERY, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
    // The last three entries are status slots: no storage past NUM_CTRL makes them read-only
    localparam logic [7:0] RW_MASK  [NUM_RW] = '{
        MASK_POWER_CONTROL, MASK_AMP_DAC_SETUP, MASK_DAC_SETUP,
        MASK_FULL, MASK_FULL, MASK_SERIAL_PORT_A,
        MASK_SERIAL_PORT_B, MASK_SLOT, MASK_SLOT,
        MASK_LEFT_LIM_RATES, MASK_LIM_THRESH, MASK_FULL,
        MASK_FULL, MASK_LIM_THRESH, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_THERMAL_GAIN,
        MASK_FAULT_RECOVERY, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};

    // Number of real control registers before soft reset entry
    localparam int NUM_CTRL = 19;
    localparam int IDX_SOFT = 19;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  ctrl_reg    [NUM_CTRL];  // Control register storage
    logic [7:0]  ctrl_next   [NUM_CTRL];  // Next values
    logic        recover_reg;             // Manual recovery pulse
    logic [7:0]  rdata_reg;               // Read data
    logic        rvalid_reg;              // Read answer strobe
    port_state_t state_reg;               // Write-port state
    port_state_t state_next;
    // Status synchronisers: two stages for pins from the analog side
    logic [31:0] stat_meta_reg;
    logic [31:0] stat_sync_reg;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // One-hot hit of an address against the writable table
    function automatic logic hit(input logic [7:0] a, input int i);
        return a == RW_ADDR[i];
    endfunction : hit

    wire         soft_req   = reg_wr_i && hit(reg_addr_i, IDX_SOFT)
                              && reg_wdata_i[BIT_SOFT_RESET];
    wire         recov_req  = reg_wr_i && (reg_addr_i == ADDR_FAULT_RECOVERY)
                              && reg_wdata_i[BIT_MANUAL_RECOVER];
    // Soft reset cycle, overrides any control register write landing in it, but not the recovery pulse
    wire         soft_apply = (state_reg == PORT_RESET);
    wire  [31:0] stat_raw   = {temperature_code_i, supply_code_i,
                               right_events_i, left_events_i,
                               power_stage_undervolt_i, regulator_undervolt_i,
                               4'h0, overtemp_fault_flag_i,
                               overtemp_warning_flag_i};
    wire  [7:0]  supply_flags  = stat_sync_reg[7:0] & MASK_SUPPLY_FLAGS;
    wire  [7:0]  channel_flags = stat_sync_reg[15:8];
    wire  [7:0]  supply_read   = stat_sync_reg[23:16];
    wire  [7:0]  temp_read     = stat_sync_reg[31:24];

    // ------------------------------------------------------------
    // Next state of control registers
    // ------------------------------------------------------------
    // Soft reset overrides, then masked host write, else hold
    genvar g;
    generate
        for (g = 0; g < NUM_CTRL; g++) begin : g_ctrl
            assign ctrl_next[g] = soft_apply ? RW_RESET[g] :
                (reg_wr_i && hit(reg_addr_i, g)) ?
                (reg_wdata_i & RW_MASK[g]) : ctrl_reg[g];
        end
    endgenerate

    // Write-port sequencing: idle, write, then a soft-reset cycle
    always_comb begin
        state_next = PORT_IDLE;
        case (state_reg)
            PORT_IDLE:  state_next = soft_req ? PORT_RESET :
                                     (reg_wr_i ? PORT_WRITE : PORT_IDLE);
            PORT_WRITE: state_next = soft_req ? PORT_RESET :
                                     (reg_wr_i ? PORT_WRITE : PORT_IDLE);
            PORT_RESET: state_next = PORT_IDLE;
            default:    state_next = PORT_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = RST_ZERO;
        case (reg_addr_i)
            ADDR_MAKER_CODE:       rd_mux = ID_MAKER_CODE;
            ADDR_PART_CODE_LOW:    rd_mux = ID_PART_LOW;
            ADDR_PART_CODE_HIGH:   rd_mux = ID_PART_HIGH;
            ADDR_SILICON_REVISION: rd_mux = ID_REVISION;
            ADDR_SUPPLY_FLAGS:     rd_mux = supply_flags;
            ADDR_CHANNEL_FLAGS:    rd_mux = channel_flags;
            ADDR_SUPPLY_READING:   rd_mux = supply_read;
            ADDR_TEMP_READING:     rd_mux = temp_read;
            ADDR_SOFT_RESET:       rd_mux = RST_ZERO;
            default: begin
                for (int i = 0; i < NUM_CTRL; i++) begin
                    if (hit(reg_addr_i, i)) begin
                        rd_mux = ctrl_reg[i];
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Control registers with reset values
    generate
        for (g = 0; g < NUM_CTRL; g++) begin : g_store
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    ctrl_reg[g] <= RW_RESET[g];
                end else begin
                    ctrl_reg[g] <= ctrl_next[g];
                end
            end
        end
    endgenerate

    // Soft reset request and manual recovery pulse
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            recover_reg  <= 1'b0;
            state_reg    <= PORT_IDLE;
        end else begin
            recover_reg  <= recov_req;
            state_reg    <= state_next;
        end
    end

    // Status synchroniser, two flip-flops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            stat_meta_reg <= 32'h0000_0000;
            stat_sync_reg <= 32'h0000_0000;
        end else begin
            stat_meta_reg <= stat_raw;
            stat_sync_reg <= stat_meta_reg;
        end
    end

    // Read answer, one cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_reg  <= RST_ZERO;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_o               = rdata_reg;
    assign reg_rvalid_o              = rvalid_reg;
    assign power_control_o           = ctrl_reg[0];
    assign amp_dac_setup_o           = ctrl_reg[1];
    assign dac_setup_o               = ctrl_reg[2];
    assign left_volume_level_o       = ctrl_reg[3];
    assign right_volume_level_o      = ctrl_reg[4];
    assign serial_port_setup_a_o     = ctrl_reg[5];
    assign serial_port_setup_b_o     = ctrl_reg[6];
    assign left_slot_o               = ctrl_reg[7][4:0];
    assign right_slot_o              = ctrl_reg[8][4:0];
    assign left_limiter_rates_o      = ctrl_reg[9];
    assign left_limiter_threshold_o  = ctrl_reg[10];
    assign left_supply_knee_o        = ctrl_reg[11];
    assign right_limiter_rates_o     = ctrl_reg[12];
    assign right_limiter_threshold_o = ctrl_reg[13];
    assign right_supply_knee_o       = ctrl_reg[14];
    assign left_clipper_level_o      = ctrl_reg[15];
    assign right_clipper_level_o     = ctrl_reg[16];
    assign thermal_gain_reduction_o  = ctrl_reg[17];
    assign fault_recovery_setup_o    = ctrl_reg[18];
    assign manual_recover_pulse_o    = recover_reg;

endmodule : amp_regmap

// *** amp_regmap_pkg.sv ***
package amp_regmap_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MAKER_CODE        = 8'h00;
    localparam logic [7:0] ADDR_PART_CODE_LOW     = 8'h01;
    localparam logic [7:0] ADDR_PART_CODE_HIGH    = 8'h02;
    localparam logic [7:0] ADDR_SILICON_REVISION  = 8'h03;
    localparam logic [7:0] ADDR_POWER_CONTROL     = 8'h04;
    localparam logic [7:0] ADDR_AMP_DAC_SETUP     = 8'h05;
    localparam logic [7:0] ADDR_DAC_SETUP         = 8'h06;
    localparam logic [7:0] ADDR_LEFT_VOLUME       = 8'h07;
    localparam logic [7:0] ADDR_RIGHT_VOLUME      = 8'h08;
    localparam logic [7:0] ADDR_SERIAL_PORT_A     = 8'h09;
    localparam logic [7:0] ADDR_SERIAL_PORT_B     = 8'h0A;
    localparam logic [7:0] ADDR_LEFT_SLOT         = 8'h0B;
    localparam logic [7:0] ADDR_RIGHT_SLOT        = 8'h0C;
    localparam logic [7:0] ADDR_LEFT_LIM_RATES    = 8'h0E;
    localparam logic [7:0] ADDR_LEFT_LIM_THRESH   = 8'h0F;
    localparam logic [7:0] ADDR_LEFT_LIM_INFL     = 8'h10;
    localparam logic [7:0] ADDR_RIGHT_LIM_RATES   = 8'h11;
    localparam logic [7:0] ADDR_RIGHT_LIM_THRESH  = 8'h12;
    localparam logic [7:0] ADDR_RIGHT_LIM_INFL    = 8'h13;
    localparam logic [7:0] ADDR_LEFT_CLIPPER      = 8'h14;
    localparam logic [7:0] ADDR_RIGHT_CLIPPER     = 8'h15;
    localparam logic [7:0] ADDR_THERMAL_GAIN      = 8'h16;
    localparam logic [7:0] ADDR_FAULT_RECOVERY    = 8'h17;
    localparam logic [7:0] ADDR_SUPPLY_FLAGS      = 8'h18;
    localparam logic [7:0] ADDR_CHANNEL_FLAGS     = 8'h19;
    localparam logic [7:0] ADDR_SUPPLY_READING    = 8'h1A;
    localparam logic [7:0] ADDR_TEMP_READING      = 8'h1B;
    localparam logic [7:0] ADDR_SOFT_RESET        = 8'h1C;

    // ------------------------------------------------------------
    // Identification values (arbitrary neutral values)
    // ------------------------------------------------------------
    localparam logic [7:0] ID_MAKER_CODE          = 8'h5A; // Arbitrary value
    localparam logic [7:0] ID_PART_LOW            = 8'hC3; // Arbitrary value
    localparam logic [7:0] ID_PART_HIGH           = 8'h7E; // Arbitrary value
    localparam logic [7:0] ID_REVISION            = 8'h0B; // Arbitrary value

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_POWER_CONTROL      = 8'hA1;
    localparam logic [7:0] RST_AMP_DAC_SETUP      = 8'h8A;
    localparam logic [7:0] RST_DAC_SETUP          = 8'h02;
    localparam logic [7:0] RST_LEFT_VOLUME        = 8'h40;
    localparam logic [7:0] RST_RIGHT_VOLUME       = 8'h40;
    localparam logic [7:0] RST_SERIAL_PORT_A      = 8'h11;
    localparam logic [7:0] RST_SERIAL_PORT_B      = 8'h07;
    localparam logic [7:0] RST_LEFT_SLOT          = 8'h00;
    localparam logic [7:0] RST_RIGHT_SLOT         = 8'h01;
    localparam logic [7:0] RST_LEFT_LIM_RATES     = 8'hA0;
    localparam logic [7:0] RST_RIGHT_LIM_RATES    = 8'hA8;
    localparam logic [7:0] RST_LIM_THRESH         = 8'h51;
    localparam logic [7:0] RST_LIM_INFL           = 8'h22;
    localparam logic [7:0] RST_CLIPPER            = 8'hFF;
    localparam logic [7:0] RST_THERMAL_GAIN       = 8'h00;
    localparam logic [7:0] RST_FAULT_RECOVERY     = 8'h30;
    localparam logic [7:0] RST_ZERO               = 8'h00;

    // ------------------------------------------------------------
    // Writable bit masks (reserved bits cleared), plus the supply flag read mask
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_POWER_CONTROL     = 8'hBD;
    localparam logic [7:0] MASK_AMP_DAC_SETUP     = 8'hBB;
    localparam logic [7:0] MASK_DAC_SETUP         = 8'hF7;
    localparam logic [7:0] MASK_FULL              = 8'hFF;
    localparam logic [7:0] MASK_SERIAL_PORT_A     = 8'h7F;
    localparam logic [7:0] MASK_SERIAL_PORT_B     = 8'h9F;
    localparam logic [7:0] MASK_SLOT              = 8'h1F;
    localparam logic [7:0] MASK_LEFT_LIM_RATES    = 8'hF7;
    localparam logic [7:0] MASK_LIM_THRESH        = 8'hFB;
    localparam logic [7:0] MASK_THERMAL_GAIN      = 8'h33;
    localparam logic [7:0] MASK_FAULT_RECOVERY    = 8'hB7;
    localparam logic [7:0] MASK_SUPPLY_FLAGS      = 8'hC3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_SOFT_RESET                 = 0;
    localparam int BIT_MANUAL_RECOVER             = 7;

    // ------------------------------------------------------------
    // Writable register indices
    // ------------------------------------------------------------
    localparam int NUM_RW                         = 23;

    // Write-port state
    typedef enum logic [1:0] {
        PORT_IDLE   = 2'b00,
        PORT_WRITE  = 2'b01,
        PORT_RESET  = 2'b10
    } port_state_t;

endpackage : amp_regmap_pkg

// *** amp_regmap_monitor.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register map checker
// ------------------------------------------------------------
module amp_regmap_monitor
    import amp_regmap_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    // Register port
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_rvalid_o,
    // Control outputs
    input wire logic [7:0] power_control_o,
    input wire logic [7:0] amp_dac_setup_o,
    input wire logic [7:0] left_volume_level_o,
    input wire logic [4:0] right_slot_o,
    input wire logic [7:0] fault_recovery_setup_o,
    input wire logic       manual_recover_pulse_o
);
    default clocking mon_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire  soft_wr = reg_wr_i && reg_addr_i == ADDR_SOFT_RESET && reg_wdata_i[0];
    wire  rec_wr  = reg_wr_i && reg_addr_i == ADDR_FAULT_RECOVERY;
    logic soft_reg; // Soft reset pulse cycle, overrides control register writes
    // Remember a soft reset write for one cycle
    always_ff @(posedge sys_clk_i) begin
        soft_reg <= soft_wr;
    end
    sequence soft_s;
        soft_wr;
    endsequence
    sequence restored_s;
        power_control_o == 8'hA1 && left_volume_level_o == 8'h40;
    endsequence
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe without answer");
    no_stray_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("answer without read strobe");
    reset_values_a: assert property (disable iff (1'b0) !rst_n_i |=>
        amp_dac_setup_o == 8'h8A && right_slot_o == 5'h01 && fault_recovery_setup_o == 8'h30)
        else $error("control registers not at reset values");
    id_read_a: assert property (reg_rd_i && reg_addr_i == ADDR_MAKER_CODE |=>
        reg_rdata_o == ID_MAKER_CODE) else $error("maker code read wrong");
    vol_write_a: assert property (reg_wr_i && reg_addr_i == ADDR_LEFT_VOLUME && !soft_reg
        |=> left_volume_level_o == $past(reg_wdata_i)) else $error("volume write lost");
    soft_reset_a: assert property (soft_s |-> ##2 restored_s)
        else $error("soft reset did not restore registers");
    reserved_zero_a: assert property ((power_control_o & 8'h42) == 8'h00 &&
        (amp_dac_setup_o & 8'h44) == 8'h00) else $error("reserved bit set");
    recover_pulse_a: assert property (rec_wr && reg_wdata_i[7] && !soft_reg
        |=> manual_recover_pulse_o) else $error("recover pulse missing");
    pulse_cause_a: assert property (!rec_wr |=> !manual_recover_pulse_o)
        else $error("recover pulse without write");
    ro_write_a: assert property (reg_wr_i && !soft_reg && reg_addr_i inside
        {[8'h00:8'h03], [8'h18:8'h1B]} |=> $stable(power_control_o) &&
        $stable(left_volume_level_o) && $stable(fault_recovery_setup_o))
        else $error("read-only write changed a register");
endmodule : amp_regmap_monitor

bind amp_regmap amp_regmap_monitor amp_regmap_monitor_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .power_control_o(power_control_o),
    .amp_dac_setup_o(amp_dac_setup_o), .left_volume_level_o(left_volume_level_o),
    .right_slot_o(right_slot_o), .fault_recovery_setup_o(fault_recovery_setup_o),
    .manual_recover_pulse_o(manual_recover_pulse_o));

// *** amp_host_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host controller issuing register strobes
// ------------------------------------------------------------
module amp_host_model (
    // Clock
    input  wire logic       sys_clk_i,
    // Strobes towards the device
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    // Answer from the device
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i
);
    // Idle lines show the inverse of the last value
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // One write strobe, held for one sampling edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        reg_wr_o    = 1'b1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(posedge sys_clk_i);
        #1;
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : wr_reg
    // One read strobe, answer taken the cycle after
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk_i);
        #1;
        reg_rd_o   = 1'b1;
        reg_addr_o = a;
        @(posedge sys_clk_i);
        #1;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
        d          = reg_rdata_i;
        v          = reg_rvalid_i;
    endtask : rd_reg
endmodule : amp_host_model

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import amp_regmap_pkg::*;
    // ------------------------------------------------------------
    // Signals and expectation tables
    // ------------------------------------------------------------
    logic        sys_clk_i, rst_n_i, pu, ru, of, ow;
    logic [3:0]  r_ev, l_ev;
    logic [7:0]  sup, tmp;
    wire         reg_wr_i, reg_rd_i, reg_rvalid_o, pulse;
    wire  [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire  [7:0]  ctl [4:23];      // Control outputs by address
    logic [7:0]  shadow [32];     // Expected contents
    logic [7:0]  rst_tab [32];    // Reset values
    logic [7:0]  mask_tab [32];   // Writable bits
    logic [15:0] lf;              // Random state
    int          err_count, check_count, cyc;
    amp_regmap amp_regmap_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .power_stage_undervolt_i(pu), .regulator_undervolt_i(ru),
        .overtemp_fault_flag_i(of), .overtemp_warning_flag_i(ow), .right_events_i(r_ev),
        .left_events_i(l_ev), .supply_code_i(sup), .temperature_code_i(tmp),
        .power_control_o(ctl[4]), .amp_dac_setup_o(ctl[5]), .dac_setup_o(ctl[6]),
        .left_volume_level_o(ctl[7]), .right_volume_level_o(ctl[8]),
        .serial_port_setup_a_o(ctl[9]), .serial_port_setup_b_o(ctl[10]),
        .left_slot_o(ctl[11][4:0]), .right_slot_o(ctl[12][4:0]),
        .left_limiter_rates_o(ctl[14]), .left_limiter_threshold_o(ctl[15]),
        .left_supply_knee_o(ctl[16]), .right_limiter_rates_o(ctl[17]),
        .right_limiter_threshold_o(ctl[18]), .right_supply_knee_o(ctl[19]),
        .left_clipper_level_o(ctl[20]), .right_clipper_level_o(ctl[21]),
        .thermal_gain_reduction_o(ctl[22]), .fault_recovery_setup_o(ctl[23]),
        .manual_recover_pulse_o(pulse));
    amp_host_model amp_host_model_inst (
        .sys_clk_i(sys_clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Read value expected at an address, status taken live
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h18:   return {pu, ru, 4'h0, of, ow};
            8'h19:   return {r_ev, l_ev};
            8'h1A:   return sup;
            8'h1B:   return tmp;
            default: return (a < 8'h20) ? shadow[a[4:0]] : 8'h00;
        endcase
    endfunction : exp_rd
    // Slot outputs are five bits wide
    function automatic logic [7:0] got_ctl(input int a);
        return (a == 11 || a == 12) ? {3'h0, ctl[a][4:0]} : ctl[a];
    endfunction : got_ctl
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
        amp_host_model_inst.wr_reg(a, d);
        if (a == 8'h1C && d[0]) begin
            shadow = rst_tab;
        end else if (a < 8'h20 && mask_tab[a[4:0]] != 8'h00) begin
            shadow[a[4:0]] = d & mask_tab[a[4:0]];
        end
    endtask : host_wr
    task automatic chk_rd(input logic [7:0] a);
        logic [7:0] d;
        logic       v;
        amp_host_model_inst.rd_reg(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp_rd(a));
    endtask : chk_rd
    // All 32 addresses 0x00 to 0x1F, then two unmapped ones above them
    task automatic sweep;
        for (int i = 0; i < 34; i++) chk_rd((i < 32) ? i[7:0] : {i[0], 7'h20});
    endtask : sweep
    task automatic check_ctl;
        @(posedge sys_clk_i);
        #1;
        for (int a = 4; a < 24; a++) if (a != 13) check(got_ctl(a), shadow[a]);
    endtask : check_ctl
    task automatic set_status;
        lf = lfsr(lf);
        {pu, ru, of, ow, r_ev, l_ev} = lf[11:0];
        sup = lf[15:8];
        tmp = lf[7:0] ^ 8'h5A;
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask : set_status
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            tally_and_finish;
        end
    end
    initial begin
        {pu, ru, of, ow, r_ev, l_ev, sup, tmp} = '0;
        rst_n_i = 1'b0;
        lf = 16'h8BEA;
        rst_tab = '{ID_MAKER_CODE, ID_PART_LOW, ID_PART_HIGH, ID_REVISION, 8'hA1, 8'h8A, 8'h02,
            8'h40, 8'h40, 8'h11, 8'h07, 8'h00, 8'h01, 8'h00, 8'hA0, 8'h51, 8'h22, 8'hA8, 8'h51,
            8'h22, 8'hFF, 8'hFF, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00};
        mask_tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hBD, 8'hBB, 8'hF7, 8'hFF, 8'hFF, 8'h7F,
            8'h9F, 8'h1F, 8'h1F, 8'h00, 8'hF7, 8'hFB, 8'hFF, 8'hFF, 8'hFB, 8'hFF, 8'hFF, 8'hFF,
            8'h33, 8'hB7, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        shadow = rst_tab;
        repeat (8) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        check_ctl;
        sweep;
        for (int a = 0; a < 28; a++) host_wr(a[7:0], 8'hFF);
        check_ctl;
        sweep;
        set_status;
        sweep;
        repeat (60) begin
            lf = lfsr(lf);
            host_wr({3'h0, lf[4:0]}, lf[15:8]);
            check_ctl;
            if (lf[6:5] == 2'b00) set_status;
            chk_rd({3'h0, lf[12:8]});
        end
        host_wr(8'h17, 8'h80);
        check({7'h00, pulse}, 8'h01);
        host_wr(8'h1C, 8'h01);
        check_ctl;
        sweep;
        tally_and_finish;
    end
endmodule : tb_top
